// ===== owcd_pkg.sv
package owcd_pkg;
  // apb map, byte addresses
  localparam logic [7:0] ADDR_WORD0  = 8'h00;
  localparam logic [7:0] ADDR_WORD1  = 8'h04;
  localparam logic [7:0] ADDR_WORD2  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  localparam int WORD_W = 13;
  localparam logic [12:0] WORD_ERASED = 13'h1FFF;

  // word zero fields
  localparam int W0_RESET_PIN  = 12;
  localparam int W0_WDOG_DIS   = 11;
  localparam int W0_INSTR_PER  = 10;
  localparam int W0_CLK_SRC_HI = 9;
  localparam int W0_CLK_SRC_LO = 8;
  localparam int W0_CODE_SEC   = 7;
  localparam int W0_SUT_HI     = 6;
  localparam int W0_SUT_LO     = 5;
  localparam int W0_TYPE       = 4;
  localparam int W0_OSC_OUT    = 3;
  localparam int W0_TRIM_HI    = 2;
  // word one fields
  localparam int W1_POWER      = 2;
  localparam int W1_IRC_HI     = 1;

  // status register fields
  localparam int ST_LOADED     = 0;
  localparam int ST_EXEC       = 1;
  localparam int ST_PROG       = 2;
  localparam int ST_TYPE_BAD   = 3;

  typedef enum logic [1:0] {
    OWCD_CLK_LXT = 2'b00,
    OWCD_CLK_HXT = 2'b01,
    OWCD_CLK_ERC = 2'b10,
    OWCD_CLK_IRC = 2'b11
  } owcd_clk_src_t;

  typedef enum logic [1:0] {
    OWCD_ST_LOAD  = 2'b00,
    OWCD_ST_WAIT  = 2'b01,
    OWCD_ST_RUN   = 2'b10
  } owcd_state_t;

  // start-up delays in microseconds and the clock rate
  localparam int CLK_MHZ   = 100;
  localparam int SUT_18_US  = 18000;
  localparam int SUT_4P5_US = 4500;
  localparam int SUT_288_US = 288000;
  localparam int SUT_72_US  = 72000;
  localparam int SUT_18_CYC  = SUT_18_US * CLK_MHZ;
  localparam int SUT_4P5_CYC = SUT_4P5_US * CLK_MHZ;
  localparam int SUT_288_CYC = SUT_288_US * CLK_MHZ;
  localparam int SUT_72_CYC  = SUT_72_US * CLK_MHZ;
  localparam int SUT_CNT_W   = 25;
endpackage

// ===== owcd_top.sv
`timescale 1ns/1ps
module owcd_top #(
  parameter int SUT_18_CYC  = owcd_pkg::SUT_18_CYC,
  parameter int SUT_4P5_CYC = owcd_pkg::SUT_4P5_CYC,
  parameter int SUT_288_CYC = owcd_pkg::SUT_288_CYC,
  parameter int SUT_72_CYC  = owcd_pkg::SUT_72_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        prog_mode_pin,
  output logic             reset_pin_en,
  output logic             wdog_en,
  output logic             instr_period_sel,
  output logic [1:0]       clk_src_sel,
  output logic             xtal_in_pin_clk,
  output logic             code_protect,
  output logic [1:0]       startup_delay_sel,
  output logic             osc_out_pin_sel,
  output logic [2:0]       rc_trim_bits,
  output logic [1:0]       irc_freq_sel,
  output logic             power_level_sel,
  output logic [12:0]      customer_id,
  output logic             exec_enable,
  output logic             instr_cycle_en,
  output logic             timer_counter_clk
);

  function automatic logic [24:0] sut_count(input logic [1:0] sel);
    case (sel)
      2'b11:   sut_count = SUT_18_CYC[24:0];
      2'b10:   sut_count = SUT_4P5_CYC[24:0];
      2'b01:   sut_count = SUT_288_CYC[24:0];
      default: sut_count = SUT_72_CYC[24:0];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // programming pin synchroniser
  logic prog_meta_reg;
  logic prog_sync_reg;
  logic prog_last_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_meta_reg <= 1'b0;
      prog_sync_reg <= 1'b0;
      prog_last_reg <= 1'b0;
    end else begin
      prog_meta_reg <= prog_mode_pin;
      prog_sync_reg <= prog_meta_reg;
      prog_last_reg <= prog_sync_reg;
    end
  end

  wire prog_exit = prog_last_reg & ~prog_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave
  logic [12:0]           word_reg [0:2];
  logic [31:0]           prdata_next;
  logic                  pslverr_next;
  logic [3:0]            status_val;
  owcd_pkg::owcd_state_t state_reg;
  owcd_pkg::owcd_state_t state_next;

  wire setup_phase  = psel & ~penable;
  wire access_done  = psel & penable & pready;
  wire sel_word0    = (paddr == owcd_pkg::ADDR_WORD0);
  wire sel_word1    = (paddr == owcd_pkg::ADDR_WORD1);
  wire sel_word2    = (paddr == owcd_pkg::ADDR_WORD2);
  wire sel_status   = (paddr == owcd_pkg::ADDR_STATUS);
  wire sel_word     = sel_word0 | sel_word1 | sel_word2;
  // option words answer only while the programmer holds the pin
  wire word_open    = sel_word & prog_sync_reg;
  wire bad_access   = ~(word_open | (sel_status & ~pwrite));
  wire [1:0] widx   = sel_word0 ? 2'd0 : (sel_word1 ? 2'd1 : 2'd2);
  wire do_write     = access_done & pwrite & word_open & ~pslverr;

  assign status_val = {word_reg[0][owcd_pkg::W0_TYPE],
                       prog_sync_reg,
                       exec_enable,
                       (state_reg != owcd_pkg::OWCD_ST_LOAD)};

  always_comb begin
    prdata_next  = 32'h0000_0000;
    pslverr_next = bad_access;
    if (word_open && !pwrite)
      prdata_next = {19'h0, word_reg[widx]};
    else if (sel_status && !pwrite)
      prdata_next = {28'h000_0000, status_val};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_phase;
      if (setup_phase) begin
        prdata  <= prdata_next;
        pslverr <= pslverr_next;
      end
    end
  end

  // erased words read as all ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++)
        word_reg[i] <= owcd_pkg::WORD_ERASED;
    end else if (do_write) begin
      word_reg[widx] <= pwdata[12:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture and start-up sequencing
  logic [24:0] sut_cnt_reg;
  wire load_now  = (state_reg == owcd_pkg::OWCD_ST_LOAD);
  wire sut_done  = (state_reg == owcd_pkg::OWCD_ST_WAIT) &&
                   (sut_cnt_reg == 25'h000_0001);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      owcd_pkg::OWCD_ST_LOAD: state_next = owcd_pkg::OWCD_ST_WAIT;
      owcd_pkg::OWCD_ST_WAIT: if (sut_done) state_next = owcd_pkg::OWCD_ST_RUN;
      owcd_pkg::OWCD_ST_RUN:  state_next = owcd_pkg::OWCD_ST_RUN;
      default:                state_next = owcd_pkg::OWCD_ST_LOAD;
    endcase
    if (prog_exit || prog_sync_reg)
      state_next = owcd_pkg::OWCD_ST_LOAD;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= owcd_pkg::OWCD_ST_LOAD;
      sut_cnt_reg <= 25'h000_0000;
      exec_enable <= 1'b0;
    end else begin
      state_reg   <= state_next;
      exec_enable <= (state_next == owcd_pkg::OWCD_ST_RUN);
      if (load_now)
        sut_cnt_reg <= sut_count(word_reg[0][6:5]);
      else if (state_reg == owcd_pkg::OWCD_ST_WAIT)
        sut_cnt_reg <= sut_cnt_reg - 25'h000_0001;
    end
  end

  // decoded fields change only in the capture state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_pin_en      <= 1'b0;
      wdog_en           <= 1'b0;
      instr_period_sel  <= 1'b1;
      clk_src_sel       <= 2'b11;
      xtal_in_pin_clk   <= 1'b0;
      code_protect      <= 1'b0;
      startup_delay_sel <= 2'b11;
      osc_out_pin_sel   <= 1'b1;
      rc_trim_bits      <= 3'h7;
      irc_freq_sel      <= 2'b11;
      power_level_sel   <= 1'b1;
      customer_id       <= 13'h1FFF;
    end else if (load_now) begin
      reset_pin_en      <= ~word_reg[0][owcd_pkg::W0_RESET_PIN];
      wdog_en           <= ~word_reg[0][owcd_pkg::W0_WDOG_DIS];
      instr_period_sel  <= word_reg[0][owcd_pkg::W0_INSTR_PER];
      clk_src_sel       <= word_reg[0][9:8];
      // crystal modes run from the crystal input, the external and internal rc modes do not
      xtal_in_pin_clk   <= ~word_reg[0][owcd_pkg::W0_CLK_SRC_HI];
      code_protect      <= ~word_reg[0][owcd_pkg::W0_CODE_SEC];
      startup_delay_sel <= word_reg[0][6:5];
      osc_out_pin_sel   <= word_reg[0][owcd_pkg::W0_OSC_OUT];
      rc_trim_bits      <= word_reg[0][2:0];
      irc_freq_sel      <= word_reg[1][1:0];
      power_level_sel   <= word_reg[1][owcd_pkg::W1_POWER];
      customer_id       <= word_reg[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction cycle and timer clock enables
  logic [1:0] div_reg;
  wire div_wrap = instr_period_sel ? (div_reg == 2'd3) : (div_reg[0] == 1'b1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg           <= 2'd0;
      instr_cycle_en    <= 1'b0;
      timer_counter_clk <= 1'b0;
    end else if (!exec_enable) begin
      div_reg           <= 2'd0;
      instr_cycle_en    <= 1'b0;
      timer_counter_clk <= 1'b0;
    end else begin
      div_reg           <= div_wrap ? 2'd0 : div_reg + 2'd1;
      instr_cycle_en    <= div_wrap;
      timer_counter_clk <= div_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_word_locked: assert property (@(posedge pclk)
    disable iff (!presetn)
    (setup_phase && sel_word && !prog_sync_reg) |=>
      (pslverr && prdata == 32'h0000_0000))
    else $error("option word reached outside programming");

  a_word_nowrite: assert property (@(posedge pclk)
    disable iff (!presetn)
    !prog_sync_reg |=> ($stable(word_reg[0]) && $stable(word_reg[1]) &&
                        $stable(word_reg[2])))
    else $error("option word changed outside programming");

  a_word_read: assert property (@(posedge pclk)
    disable iff (!presetn)
    (setup_phase && word_open && !pwrite) |=>
      (prdata == {19'h0, $past(word_reg[widx])}))
    else $error("option word read data wrong");

  a_word_store: assert property (@(posedge pclk)
    disable iff (!presetn)
    do_write |=> (word_reg[$past(widx)] == $past(pwdata[12:0])))
    else $error("option word write lost");

  a_reset_pin: assert property (@(posedge pclk)
    disable iff (!presetn)
    load_now |=> (reset_pin_en == ~$past(word_reg[0][12])))
    else $error("reset pin function wrong");

  a_wdog_map: assert property (@(posedge pclk)
    disable iff (!presetn)
    load_now |=> (wdog_en != $past(word_reg[0][11])))
    else $error("watchdog option wrong");

  a_period_sel: assert property (@(posedge pclk)
    disable iff (!presetn)
    load_now |=>
      (instr_period_sel == $past(word_reg[0][owcd_pkg::W0_INSTR_PER])))
    else $error("instruction period decode wrong");

  a_period_four: assert property (@(posedge pclk)
    disable iff (!presetn)
    (exec_enable && instr_period_sel && instr_cycle_en) |=>
      !instr_cycle_en[*3] ##1 (instr_cycle_en || !exec_enable))
    else $error("four period spacing wrong");

  a_timer_four: assert property (@(posedge pclk)
    disable iff (!presetn)
    ($rose(timer_counter_clk) && instr_period_sel && exec_enable) |=>
      !timer_counter_clk[*3] ##1 (timer_counter_clk || !exec_enable))
    else $error("timer clock not divided by four");

  a_timer_two: assert property (@(posedge pclk)
    disable iff (!presetn)
    (timer_counter_clk && !instr_period_sel && exec_enable) |=>
      !timer_counter_clk ##1 (timer_counter_clk || !exec_enable))
    else $error("timer clock not divided by two");

  a_cycle_idle: assert property (@(posedge pclk)
    disable iff (!presetn)
    !exec_enable |=> (!instr_cycle_en && !timer_counter_clk))
    else $error("cycle enable pulsed while halted");

  a_clk_src: assert property (@(posedge pclk)
    disable iff (!presetn)
    load_now |=> (clk_src_sel == $past(word_reg[0][9:8]) &&
                  xtal_in_pin_clk == !clk_src_sel[1]))
    else $error("clock source decode wrong");

  a_code_prot: assert property (@(posedge pclk)
    disable iff (!presetn)
    load_now |=>
      (code_protect == ~$past(word_reg[0][owcd_pkg::W0_CODE_SEC])))
    else $error("code security decode wrong");

  a_sut_sel: assert property (@(posedge pclk)
    disable iff (!presetn)
    load_now |=> (startup_delay_sel == $past(word_reg[0][6:5])))
    else $error("start-up delay select wrong");

  a_sut_load: assert property (@(posedge pclk)
    disable iff (!presetn)
    (load_now && !prog_sync_reg && !prog_exit) |=>
      (sut_cnt_reg == sut_count($past(word_reg[0][6:5]))))
    else $error("start-up delay count wrong");

  a_osc_out: assert property (@(posedge pclk)
    disable iff (!presetn)
    load_now |=>
      (osc_out_pin_sel == $past(word_reg[0][owcd_pkg::W0_OSC_OUT])))
    else $error("oscillator output pin decode wrong");

  a_irc_freq: assert property (@(posedge pclk)
    disable iff (!presetn)
    load_now |=> (irc_freq_sel == $past(word_reg[1][1:0])))
    else $error("internal rc frequency decode wrong");

  a_trim_apply: assert property (@(posedge pclk)
    disable iff (!presetn)
    load_now |=> (rc_trim_bits == $past(word_reg[0][2:0])))
    else $error("rc trim bits not applied");

  a_power_sel: assert property (@(posedge pclk)
    disable iff (!presetn)
    load_now |=>
      (power_level_sel == $past(word_reg[1][owcd_pkg::W1_POWER])))
    else $error("power level decode wrong");

  a_cust_id: assert property (@(posedge pclk)
    disable iff (!presetn)
    load_now |=> (customer_id == $past(word_reg[2])))
    else $error("customer code not captured");

  a_static_hold: assert property (@(posedge pclk)
    disable iff (!presetn)
    !load_now |=> $stable({code_protect, rc_trim_bits, irc_freq_sel,
                           power_level_sel, customer_id}))
    else $error("captured option changed while running");

  a_hold_prog: assert property (@(posedge pclk)
    disable iff (!presetn)
    prog_sync_reg |=> !exec_enable)
    else $error("execution ran during programming");

  a_exec_after: assert property (@(posedge pclk)
    disable iff (!presetn)
    $rose(exec_enable) |-> $past(sut_done))
    else $error("execution began before start-up delay");

endmodule

// ===== owcd_prog_model.sv
`timescale 1ns/1ps
module owcd_prog_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             prog_mode_pin
);
  initial begin
    {psel, penable, pwrite, prog_mode_pin} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  //////////////////////////////////////////////////////////////////////
  // one apb transfer; r returns {pslverr, prdata}
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [32:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic open_s();
    @(posedge pclk);
    prog_mode_pin <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  // type bit always zero, trim bits always ones
  task automatic burn0(input logic [12:0] w);
    logic [32:0] r;
    xfer(1'b1, owcd_pkg::ADDR_WORD0, {19'h0, w[12:5], 1'b0, w[3], 3'h7}, r);
  endtask
  task automatic close_s();
    @(posedge pclk);
    prog_mode_pin <= 1'b0;
  endtask
endmodule

// ===== option_word_config_decode_test.sv
`timescale 1ns/1ps
module option_word_config_decode_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        reset_pin_en, wdog_en, instr_period_sel, xtal_in_pin_clk;
  logic        code_protect, osc_out_pin_sel, power_level_sel, exec_enable;
  logic        instr_cycle_en, timer_counter_clk;
  logic [1:0]  clk_src_sel, startup_delay_sel, irc_freq_sel;
  logic [2:0]  rc_trim_bits;
  logic [12:0] customer_id;
  int          err_total = 0;
  int          compares = 0;
  int          cyc = 0;
  owcd_top #(.SUT_18_CYC(20), .SUT_4P5_CYC(10), .SUT_288_CYC(80),
    .SUT_72_CYC(40)) owcd_top_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .prog_mode_pin(pin), .reset_pin_en, .wdog_en, .instr_period_sel,
    .clk_src_sel, .xtal_in_pin_clk, .code_protect, .startup_delay_sel,
    .osc_out_pin_sel, .rc_trim_bits, .irc_freq_sel, .power_level_sel,
    .customer_id, .exec_enable, .instr_cycle_en, .timer_counter_clk);
  owcd_prog_model owcd_prog_model_inst (.pclk, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .prog_mode_pin(pin));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  function automatic logic [32:0] decode();
    return {17'h0, reset_pin_en, wdog_en, instr_period_sel, clk_src_sel,
      xtal_in_pin_clk, code_protect, startup_delay_sel, osc_out_pin_sel,
      rc_trim_bits, irc_freq_sel, power_level_sel};
  endfunction
  task automatic tick(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (timer_counter_clk !== 1'b1 && n < 20);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic erased_check();
    chk(decode(), {17'h0, 16'b0_0_1_11_0_0_11_1_111_11_1});
    chk({20'h0, customer_id}, 33'h1FFF);
  endtask
  task automatic sess(input logic [1:0] c);
    logic [32:0] r;
    logic [12:0] w0;
    int n;
    int cnt;
    w0 = {c[0], ~c[0], c[1], c, c[0], c, 1'b0, c[1], 3'h7};
    cnt = (c == 2'b11) ? 20 : (c == 2'b10) ? 10 : (c == 2'b01) ? 80 : 40;
    owcd_prog_model_inst.open_s();
    owcd_prog_model_inst.burn0(w0);
    owcd_prog_model_inst.xfer(1'b1, owcd_pkg::ADDR_WORD1,
      {29'h0, c[0], c}, r);
    owcd_prog_model_inst.xfer(1'b1, owcd_pkg::ADDR_WORD2,
      {19'h0, 11'h2A5, c}, r);
    owcd_prog_model_inst.xfer(1'b0, owcd_pkg::ADDR_WORD2, 32'h0, r);
    chk(r, {20'h0, 11'h2A5, c});
    owcd_prog_model_inst.close_s();
    n = 0;
    while (exec_enable !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk(33'(n >= cnt && n <= cnt + 8), 33'h1);
    chk(decode() >> 11, {28'h0, ~c[0], c[0], c[1], c});
    chk((decode() >> 7) & 33'hF, {29'h0, ~c[1], ~c[0], c});
    chk(decode() & 33'h7F, {26'h0, c[1], 3'h7, c, c[0]});
    chk({20'h0, customer_id}, {20'h0, 11'h2A5, c});
    tick(n);
    tick(n);
    chk(33'(n), c[1] ? 33'h4 : 33'h2);
  endtask
  task automatic refuse();
    logic [32:0] r;
    owcd_prog_model_inst.xfer(1'b1, owcd_pkg::ADDR_WORD2, 32'h0, r);
    chk({32'h0, r[32]}, 33'h1);
    owcd_prog_model_inst.xfer(1'b0, owcd_pkg::ADDR_WORD0, 32'h0, r);
    chk(r, 33'h1_0000_0000);
    owcd_prog_model_inst.xfer(1'b1, owcd_pkg::ADDR_STATUS, 32'h0, r);
    chk({32'h0, r[32]}, 33'h1);
    owcd_prog_model_inst.xfer(1'b0, 8'h10, 32'h0, r);
    chk(r, 33'h1_0000_0000);
    // running and loaded, pin low, type bit zero
    owcd_prog_model_inst.xfer(1'b0, owcd_pkg::ADDR_STATUS, 32'h0, r);
    chk(r, 33'h3);
    chk({20'h0, customer_id}, {20'h0, 11'h2A5, 2'b11});
    // the refused write must not have reached word two
    owcd_prog_model_inst.open_s();
    owcd_prog_model_inst.xfer(1'b0, owcd_pkg::ADDR_WORD2, 32'h0, r);
    chk(r, {20'h0, 11'h2A5, 2'b11});
    owcd_prog_model_inst.close_s();
  endtask
  task automatic mid_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    erased_check();
  endtask
  initial begin
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    erased_check();
    for (int i = 0; i < 4; i++)
      sess(2'(i));
    refuse();
    mid_reset();
    test_done();
  end
endmodule
